//--- core/gcs_top.sv
// Purpose: General configuration and data control registers with sync
// Assumes: sys_clk is the master clock; serial clock is far slower than it
// Notes: Serial pins are oversampled, so the serial clock must stay below
//   about one eighth of sys_clk
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Retime bit set drives sync output from the other master clock edge.
// - Buffer power-down bit set turns the common-mode buffer off.
// - Two-bit select picks half supply, 1.65 V, 2.5 V or 2.14 V.
// - Channel 0 in standby also disables the common-mode output.
// - Sync recognised only at the last serial clock rise of that write.
// - Recognised sync drives a master-clock aligned pulse on sync output.
// - General configuration at 0x05, resets to 0x08.
// - Data control at 0x06, resets to 0x80, sync bit high.
module gcs_top #(
  parameter int SYNC_PULSE_CYCLES = gcs_pkg::GCS_SYNC_PULSE_CYCLES,
  parameter int SETTLE_CYCLES = gcs_pkg::GCS_SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial register port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Sync pins
  input wire logic start_n,
  input wire logic sync_in_n,
  output logic sync_out_n,
  // Channel state from the converter core
  input wire logic channel0_standby,
  // Common-mode control
  output gcs_pkg::gcs_cm_ctrl_t common_mode_output,
  // Filter control
  output logic filter_reset,
  output logic data_output_enable
);
  import gcs_pkg::*;

  localparam logic [15:0] PULSE_LEN = 16'(SYNC_PULSE_CYCLES);
  localparam logic [15:0] SETTLE_LEN = 16'(SETTLE_CYCLES);

  logic sclk_s, cs_n_s, mosi_s, start_n_s, sync_in_n_s;

  gcs_sync2 #(
    .WIDTH(5),
    .RESET_VAL(5'h1f)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({sclk, cs_n, mosi, start_n, sync_in_n}),
    .sync_out({sclk_s, cs_n_s, mosi_s, start_n_s, sync_in_n_s})
  );

  function automatic logic [7:0] read_mux(input logic [6:0] addr,
                                          input logic [7:0] gen,
                                          input logic [7:0] ctl);
    case (addr)
      GCS_ADDR_GEN_CFG: read_mux = gen;
      GCS_ADDR_DATA_CTRL: read_mux = ctl;
      default: read_mux = GCS_UNMAPPED_READ;
    endcase
  endfunction

  // Serial shifter state
  logic sclk_prev_q, sclk_prev_d;
  logic start_prev_q, start_prev_d;
  logic sync_prev_q, sync_prev_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [15:0] shift_q, shift_d;
  logic [7:0] out_q, out_d;
  logic [6:0] addr_q, addr_d;
  logic rd_q, rd_d;
  // Registers
  logic [7:0] gen_cfg_q, gen_cfg_d;
  logic [7:0] data_ctrl_q, data_ctrl_d;
  // Sync and settling
  logic soft_sync;
  logic [15:0] pulse_cnt_q, pulse_cnt_d;
  logic sync_pos_n_q, sync_pos_n_d;
  logic sync_neg_n_q;
  logic filt_rst_q, filt_rst_d;
  logic [15:0] settle_q, settle_d;
  logic settled_q, settled_d;

  logic sclk_rise, sclk_fall;
  gcs_frame_t frame;

  always_comb begin
    sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
    sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
    sclk_prev_d = sclk_s;
    start_prev_d = start_n_s;
    sync_prev_d = sync_in_n_s;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    out_d = out_q;
    addr_d = addr_q;
    rd_d = rd_q;
    gen_cfg_d = gen_cfg_q;
    data_ctrl_d = data_ctrl_q;
    soft_sync = 1'b0;
    frame = gcs_frame_t'({shift_q[14:0], mosi_s});
    if (cs_n_s) begin
      // Deselect aborts any partial frame; nothing is written
      bit_cnt_d = 5'h00;
      out_d = 8'h00;
    end else if (sclk_rise && bit_cnt_q != GCS_FRAME_BITS) begin
      shift_d = {shift_q[14:0], mosi_s};
      bit_cnt_d = bit_cnt_q + 5'h01;
      if (bit_cnt_q == GCS_FRAME_BITS - 5'h01 && !frame.rd) begin
        case (frame.addr)
          GCS_ADDR_GEN_CFG: gen_cfg_d = frame.data;
          GCS_ADDR_DATA_CTRL: begin
            data_ctrl_d = frame.data;
            soft_sync = frame.data[GCS_BIT_SOFT_SYNC] &
                        ~data_ctrl_q[GCS_BIT_SOFT_SYNC];
          end
          default: ;
        endcase
      end
    end else if (sclk_fall) begin
      if (bit_cnt_q == GCS_HDR_BITS) begin
        rd_d = shift_q[7];
        addr_d = shift_q[6:0];
        out_d = shift_q[7] ? read_mux(shift_q[6:0], gen_cfg_q, data_ctrl_q)
                           : 8'h00;
      end else if (bit_cnt_q > GCS_HDR_BITS) begin
        out_d = {out_q[6:0], 1'b0};
      end
    end
  end

  always_comb begin
    pulse_cnt_d = pulse_cnt_q;
    // Soft sync and start pin share one pulse
    if (soft_sync || (!start_n_s && start_prev_q)) begin
      pulse_cnt_d = PULSE_LEN;
    end else if (pulse_cnt_q != 16'h0000) begin
      pulse_cnt_d = pulse_cnt_q - 16'h0001;
    end
    sync_pos_n_d = (pulse_cnt_q == 16'h0000);
    filt_rst_d = ~sync_in_n_s & sync_prev_q;
    settle_d = settle_q;
    settled_d = settled_q;
    if (filt_rst_q) begin
      settle_d = SETTLE_LEN;
      settled_d = 1'b0;
    end else if (settle_q != 16'h0000) begin
      settle_d = settle_q - 16'h0001;
    end else begin
      settled_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_q <= 1'b1;
      start_prev_q <= 1'b1;
      sync_prev_q <= 1'b1;
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      out_q <= 8'h00;
      addr_q <= 7'h00;
      rd_q <= 1'b0;
      gen_cfg_q <= GCS_RST_GEN_CFG;
      data_ctrl_q <= GCS_RST_DATA_CTRL;
      pulse_cnt_q <= 16'h0000;
      sync_pos_n_q <= 1'b1;
      filt_rst_q <= 1'b0;
      settle_q <= 16'h0000;
      settled_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      start_prev_q <= start_prev_d;
      sync_prev_q <= sync_prev_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      out_q <= out_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      gen_cfg_q <= gen_cfg_d;
      data_ctrl_q <= data_ctrl_d;
      pulse_cnt_q <= pulse_cnt_d;
      sync_pos_n_q <= sync_pos_n_d;
      filt_rst_q <= filt_rst_d;
      settle_q <= settle_d;
      settled_q <= settled_d;
    end
  end

  always_ff @(negedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_neg_n_q <= 1'b1;
    end else begin
      sync_neg_n_q <= sync_pos_n_q;
    end
  end

  assign sync_out_n = gen_cfg_q[GCS_BIT_RETIME] ? sync_neg_n_q : sync_pos_n_q;
  assign miso = out_q[7];
  assign miso_oe = ~cs_n_s;
  // One process drives the whole struct, so it has a single driver
  always_comb begin
    common_mode_output.buffer_powerdown = gen_cfg_q[GCS_BIT_CM_PWRDN];
    common_mode_output.voltage_select = gen_cfg_q[GCS_VSEL_LSB +: 2];
    common_mode_output.output_enable =
      ~gen_cfg_q[GCS_BIT_CM_PWRDN] & ~channel0_standby;
  end
  assign filter_reset = filt_rst_q;
  assign data_output_enable = settled_q & ~filt_rst_q;
endmodule
`default_nettype wire

//--- core/gcs_pkg.sv
// Purpose: Shared constants and types of the configuration and sync block
// Assumes: 16-bit serial frames: read flag, 7-bit address, 8-bit data
// Notes: Offsets are the register addresses carried in the frame
package gcs_pkg;
  localparam int GCS_ADDR_W = 7;
  localparam int GCS_DATA_W = 8;
  localparam int GCS_FRAME_W = 16;
  localparam logic [4:0] GCS_FRAME_BITS = 5'h10;
  localparam logic [4:0] GCS_HDR_BITS = 5'h08;

  localparam logic [6:0] GCS_ADDR_GEN_CFG = 7'h05;
  localparam logic [6:0] GCS_ADDR_DATA_CTRL = 7'h06;
  localparam logic [7:0] GCS_RST_GEN_CFG = 8'h08;
  localparam logic [7:0] GCS_RST_DATA_CTRL = 8'h80;
  localparam logic [7:0] GCS_UNMAPPED_READ = 8'h00;

  // General configuration fields
  localparam int GCS_BIT_RETIME = 5;
  localparam int GCS_BIT_CM_PWRDN = 4;
  localparam int GCS_VSEL_LSB = 0;
  // Data control fields
  localparam int GCS_BIT_SOFT_SYNC = 7;

  // Common-mode voltage select encodings
  localparam logic [1:0] GCS_VSEL_HALF_SUPPLY = 2'h0;
  localparam logic [1:0] GCS_VSEL_1V65 = 2'h1;
  localparam logic [1:0] GCS_VSEL_2V5 = 2'h2;
  localparam logic [1:0] GCS_VSEL_2V14 = 2'h3;

  // Timing counts in master clock cycles
  localparam int GCS_SYNC_PULSE_CYCLES = 4;
  localparam int GCS_SETTLE_CYCLES = 1024;

  typedef struct packed {
    logic rd;
    logic [GCS_ADDR_W-1:0] addr;
    logic [GCS_DATA_W-1:0] data;
  } gcs_frame_t;

  typedef struct packed {
    logic buffer_powerdown;
    logic [1:0] voltage_select;
    logic output_enable;
  } gcs_cm_ctrl_t;
endpackage

//--- core/gcs_sync2.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are slow levels relative to sys_clk
// Notes: Stage one is read only by stage two
`timescale 1ns/1ns
`default_nettype none
module gcs_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

//--- test/gcs_host.sv
// Purpose: Serial host model driving the register port
// Assumes: Mode 3 framing, six sys_clk cycles per serial clock phase
// Notes: Data line is inverted once released so stale values never match
`timescale 1ns/1ns
`default_nettype none
module gcs_host (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  import gcs_pkg::*;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input gcs_frame_t f, output logic [7:0] rd);
    rd = '0;
    cs_n <= 1'b0;
    for (int i = GCS_FRAME_W - 1; i >= 0; i--) begin
      repeat (6) @(posedge sys_clk);
      sclk <= 1'b0;
      mosi <= f[i];
      repeat (6) @(posedge sys_clk);
      // Read data is taken just before the rising edge
      if (i < 8) rd[i] = miso;
      sclk <= 1'b1;
    end
    repeat (6) @(posedge sys_clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- test/gcs_top_sva.sv
// Purpose: Port checker for gcs_top
// Assumes: Default pulse length and a settle count of eight
// Notes: Counts below are literal, so keep them in step with the bind
`timescale 1ns/1ns
`default_nettype none
module gcs_top_sva #(
  parameter int SYNC_PULSE_CYCLES = 4,
  parameter int SETTLE_CYCLES = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial and sync pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic start_n,
  input wire logic sync_in_n,
  input wire logic sync_out_n,
  // Core side
  input wire logic channel0_standby,
  input wire gcs_pkg::gcs_cm_ctrl_t common_mode_output,
  input wire logic filter_reset,
  input wire logic data_output_enable
);
  import gcs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_sync_low;
    !sync_out_n [*4];
  endsequence
  sequence s_in_edge;
    $fell(sync_in_n);
  endsequence
  a_cm_enable: assert property (
    common_mode_output.output_enable == (!channel0_standby &&
    !common_mode_output.buffer_powerdown)) else $error("cm enable wrong");
  a_sync_width: assert property (
    $fell(sync_out_n) |-> s_sync_low) else $error("sync pulse short");
  a_start_sync: assert property (
    $fell(start_n) |-> ##[2:8] !sync_out_n) else $error("start no pulse");
  a_filter_cause: assert property (
    s_in_edge |-> ##[1:6] filter_reset) else $error("no filter reset");
  a_settle_hold: assert property (
    filter_reset |-> !data_output_enable [*8]) else $error("data too early");
  a_doe_recover: assert property (
    $rose(data_output_enable) |-> $past(filter_reset, 10))
    else $error("settle length wrong");
  a_vsel_stable: assert property (
    cs_n [*6] |-> $stable(common_mode_output.voltage_select) &&
    $stable(common_mode_output.buffer_powerdown)) else $error("cm drift");
  a_no_spurious: assert property (
    (cs_n && start_n) [*8] |=> !$fell(sync_out_n)) else $error("stray sync");
  a_oe_off_idle: assert property (
    cs_n [*3] |-> !miso_oe) else $error("miso driven while idle");
  a_oe_on_select: assert property (
    !cs_n [*3] |-> miso_oe) else $error("miso not driven when selected");
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Purpose: Self-checking bench for the configuration and sync block
// Assumes: Sync output is looped back to the sync input
// Notes: A small settle count keeps the run short
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gcs_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, start_n = 1'b1, ch0_sb = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe, sync_n, filter_reset, doe;
  gcs_cm_ctrl_t cm;
  logic [7:0] rd_seen, g;
  logic rd_valid = 1'b0;
  logic [7:0] exp_q[$];
  int failures = 0, total_checks = 0, pulses = 0, fr = 0, ph = 0, p = 0;
  int fr_mark = 0;
  always #5 sys_clk = ~sys_clk;
  gcs_host host_u (.sys_clk(sys_clk), .miso(miso), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi));
  gcs_top #(.SETTLE_CYCLES(8)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .start_n(start_n), .sync_in_n(sync_n), .sync_out_n(sync_n),
    .channel0_standby(ch0_sb), .common_mode_output(cm),
    .filter_reset(filter_reset), .data_output_enable(doe));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("FAIL t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    host_u.xfer({1'b0, a, d}, x);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.xfer({1'b1, a, 8'h00}, rd_seen);
    rd_valid <= 1'b1;
    @(posedge sys_clk);
    rd_valid <= 1'b0;
  endtask
  always @(posedge sys_clk) begin
    if (rd_valid) begin
      chk(rd_seen, exp_q.pop_front());
    end
  end
  always @(negedge sync_n) begin
    pulses++;
    ph = $time % 10;
  end
  always @(posedge sys_clk) if (filter_reset === 1'b1) fr++;
  task automatic soft_sync(input logic re);
    int p0, f0;
    p0 = pulses;
    f0 = fr;
    // one, then zero, then one in a later write
    wr(GCS_ADDR_DATA_CTRL, 8'h80);
    wr(GCS_ADDR_DATA_CTRL, 8'h00);
    chk(8'(pulses - p0), 8'h00);
    wr(GCS_ADDR_DATA_CTRL, 8'h80);
    for (int i = 0; i < 50 && fr == f0; i++) @(posedge sys_clk);
    chk(8'(pulses - p0), 8'h01);
    chk(8'(ph), re ? 8'h00 : 8'h05);
    chk(8'(fr - f0), 8'h01);
    // Sample well inside the hold-off, never on the edge that ends it
    repeat (3) @(posedge sys_clk);
    chk({7'h00, doe}, 8'h00);
    repeat (14) @(posedge sys_clk);
    chk({7'h00, doe}, 8'h01);
  endtask
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h8249));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(GCS_ADDR_GEN_CFG, GCS_RST_GEN_CFG);
    rd(GCS_ADDR_DATA_CTRL, GCS_RST_DATA_CTRL);
    $display("test reset values done");
    for (int v = 0; v < 4; v++) begin
      g = (8'($urandom) & 8'h1c) | 8'(v);
      ch0_sb <= 1'($urandom);
      wr(GCS_ADDR_GEN_CFG, g);
      rd(GCS_ADDR_GEN_CFG, g);
      chk({4'h0, cm}, {4'h0, g[4], g[1:0], ~g[4] & ~ch0_sb});
    end
    // channel 0 back on while the common-mode output is in use
    ch0_sb <= 1'b0;
    $display("test common mode done");
    wr(7'h07, 8'h5a);
    rd(7'h07, GCS_UNMAPPED_READ);
    rd(GCS_ADDR_GEN_CFG, g);
    $display("test unmapped done");
    soft_sync(1'b0);
    wr(GCS_ADDR_GEN_CFG, 8'h20);
    soft_sync(1'b1);
    $display("test soft sync done");
    p = pulses;
    fr_mark = fr;
    // two successive pulses, as a chain of parts needs
    repeat (2) begin
      start_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      start_n <= 1'b1;
      repeat (30) @(posedge sys_clk);
    end
    chk(8'(pulses - p), 8'h02);
    chk(8'(fr - fr_mark), 8'h02);
    $display("test start pin done");
    end_of_test();
  end
endmodule
bind gcs_top gcs_top_sva #(.SYNC_PULSE_CYCLES(SYNC_PULSE_CYCLES),
  .SETTLE_CYCLES(SETTLE_CYCLES)) sva_u (.sys_clk(sys_clk),
  .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
  .miso_oe(miso_oe), .start_n(start_n), .sync_in_n(sync_in_n),
  .sync_out_n(sync_out_n), .channel0_standby(channel0_standby),
  .common_mode_output(common_mode_output), .filter_reset(filter_reset),
  .data_output_enable(data_output_enable));
`default_nettype wire
